// File: common/tscr_pkg.sv
// constants shared by the tuner configuration register bank
package tscr_pkg;

  // register pointer values as printed
  localparam logic [7:0] TSCR_ADDR_SYNTH   = 8'h06;
  localparam logic [7:0] TSCR_ADDR_OSC     = 8'h07;
  localparam logic [7:0] TSCR_ADDR_LOWPASS = 8'h08;
  localparam logic [7:0] TSCR_ADDR_CONTROL = 8'h09;
  localparam logic [7:0] TSCR_ADDR_SHUTDN  = 8'h0a;

  // 7-bit slave address with the strap bit in position 0
  localparam logic [6:0] TSCR_SLAVE_BASE   = 7'h60;

  // values after reset
  localparam logic [7:0] TSCR_RST_SYNTH    = 8'hc0;
  localparam logic [7:0] TSCR_RST_OSC      = 8'hcc;
  localparam logic [7:0] TSCR_RST_LOWPASS  = 8'h4b;
  localparam logic [7:0] TSCR_RST_CONTROL  = 8'h00;
  localparam logic [7:0] TSCR_RST_SHUTDN   = 8'h00;

  // bits that are stored; the rest are don't care
  localparam logic [7:0] TSCR_MASK_SYNTH   = 8'he0;
  localparam logic [7:0] TSCR_MASK_OSC     = 8'hff;
  localparam logic [7:0] TSCR_MASK_LOWPASS = 8'hff;
  localparam logic [7:0] TSCR_MASK_CONTROL = 8'haf;
  localparam logic [7:0] TSCR_MASK_SHUTDN  = 8'h7f;

  // field positions
  localparam int TSCR_BIT_DIVSEL   = 7;
  localparam int TSCR_BIT_PUMPSRC  = 6;
  localparam int TSCR_BIT_PUMPLVL  = 5;
  localparam int TSCR_BIT_BAND_MSB = 7;
  localparam int TSCR_BIT_BAND_LSB = 3;
  localparam int TSCR_BIT_AUTOSEL  = 2;
  localparam int TSCR_BIT_ADCLAT   = 1;
  localparam int TSCR_BIT_ADCRD    = 0;
  localparam int TSCR_BIT_STANDBY  = 7;
  localparam int TSCR_BIT_FACTPD   = 5;
  localparam int TSCR_BIT_GAIN_MSB = 3;
  localparam int TSCR_BIT_SYNTHOFF = 6;
  localparam int TSCR_BIT_DIVOFF   = 5;
  localparam int TSCR_BIT_OSCOFF   = 4;
  localparam int TSCR_BIT_BBOFF    = 3;
  localparam int TSCR_BIT_MIXOFF   = 2;
  localparam int TSCR_BIT_AMPOFF   = 1;
  localparam int TSCR_BIT_FEOFF    = 0;

  // serial byte framing
  localparam logic [3:0] TSCR_BITS_PER_BYTE = 4'h8;

endpackage : tscr_pkg

// File: common/tscr_line_if.sv
// line events passed from the edge detector to the serial slave
`timescale 1ns/100ps
`default_nettype none
interface tscr_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_bit;
  modport src (output scl_rise, output scl_fall, output start_det, output stop_det, output sda_bit);
  modport dst (input scl_rise, input scl_fall, input start_det, input stop_det, input sda_bit);
endinterface : tscr_line_if
`default_nettype wire

// File: src/tscr_line_edge.sv
// edge, start and stop detection on the two serial lines
`timescale 1ns/100ps
`default_nettype none
module tscr_line_edge
  import tscr_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // serial lines
  input  wire logic scl,
  input  wire logic sda,
  // events
  tscr_line_if.src  ev
);

  logic scl_ff;
  logic sda_ff;

  // idle bus is high, so reset to high to avoid a false edge
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
    end
  end

  assign ev.scl_rise  = scl & ~scl_ff;
  assign ev.scl_fall  = ~scl & scl_ff;
  assign ev.start_det = scl & scl_ff & sda_ff & ~sda;
  assign ev.stop_det  = scl & scl_ff & ~sda_ff & sda;
  assign ev.sda_bit   = sda;

endmodule : tscr_line_edge
`default_nettype wire

// File: src/tscr_field_decode.sv
// registered decode of stored register bytes into control outputs
`timescale 1ns/100ps
`default_nettype none
module tscr_field_decode
  import tscr_pkg::*;
(
  // clock
  input  wire logic       clk,
  input  wire logic       reset,
  // register values, next-state form
  input  wire logic [7:0] synth_val,
  input  wire logic [7:0] osc_val,
  input  wire logic [7:0] lowpass_val,
  input  wire logic [7:0] control_val,
  input  wire logic [7:0] shutdn_val,
  // decoded controls
  output logic            osc_out_divide_sel,
  output logic            pump_current_source_sel,
  output logic            pump_current_level,
  output logic [4:0]      oscillator_band_code,
  output logic            auto_band_select_en,
  output logic            tune_adc_latch,
  output logic            tune_adc_read_en,
  output logic [7:0]      baseband_corner_code,
  output logic            standby_ctl,
  output logic            factory_power_down,
  output logic [3:0]      baseband_gain_code,
  output logic            synth_off,
  output logic            divider_off,
  output logic            oscillator_off,
  output logic            baseband_off,
  output logic            rf_mixer_off,
  output logic            rf_amp_off,
  output logic            front_end_off
);

  // inputs already carry reset values while reset is high
  always_ff @(posedge clk) begin
    osc_out_divide_sel      <= synth_val[TSCR_BIT_DIVSEL];
    pump_current_source_sel <= synth_val[TSCR_BIT_PUMPSRC];
    pump_current_level      <= ~synth_val[TSCR_BIT_PUMPSRC] & synth_val[TSCR_BIT_PUMPLVL];
    oscillator_band_code    <= osc_val[TSCR_BIT_BAND_MSB:TSCR_BIT_BAND_LSB];
    auto_band_select_en     <= osc_val[TSCR_BIT_AUTOSEL];
    tune_adc_latch          <= ~osc_val[TSCR_BIT_AUTOSEL] & osc_val[TSCR_BIT_ADCLAT];
    tune_adc_read_en        <= ~osc_val[TSCR_BIT_AUTOSEL] & osc_val[TSCR_BIT_ADCRD];
    baseband_corner_code    <= lowpass_val;
    standby_ctl             <= control_val[TSCR_BIT_STANDBY];
    factory_power_down      <= control_val[TSCR_BIT_FACTPD];
    baseband_gain_code      <= control_val[TSCR_BIT_GAIN_MSB:0];
    // standby gates the signal path and synthesizer; bus and crystal stay up
    synth_off      <= shutdn_val[TSCR_BIT_SYNTHOFF] | control_val[TSCR_BIT_STANDBY];
    divider_off    <= shutdn_val[TSCR_BIT_DIVOFF]   | control_val[TSCR_BIT_STANDBY];
    oscillator_off <= shutdn_val[TSCR_BIT_OSCOFF]   | control_val[TSCR_BIT_STANDBY];
    baseband_off   <= shutdn_val[TSCR_BIT_BBOFF]    | control_val[TSCR_BIT_STANDBY];
    rf_mixer_off   <= shutdn_val[TSCR_BIT_MIXOFF]   | control_val[TSCR_BIT_STANDBY];
    rf_amp_off     <= shutdn_val[TSCR_BIT_AMPOFF]   | control_val[TSCR_BIT_STANDBY];
    front_end_off  <= shutdn_val[TSCR_BIT_FEOFF]    | control_val[TSCR_BIT_STANDBY];
  end

  pump_exclusive_a: assert property (@(posedge clk) disable iff (reset)
    pump_current_source_sel |-> !pump_current_level)
    else $error("pump level active while auto source selected");

  adc_gated_a: assert property (@(posedge clk) disable iff (reset)
    auto_band_select_en |-> !tune_adc_latch && !tune_adc_read_en)
    else $error("adc controls active while auto select on");

  standby_all_off_a: assert property (@(posedge clk) disable iff (reset)
    standby_ctl |-> synth_off && divider_off && oscillator_off && baseband_off
      && rf_mixer_off && rf_amp_off && front_end_off)
    else $error("standby left a block running");

endmodule : tscr_field_decode
`default_nettype wire

// File: src/tscr_config_regs.sv
// serial write slave and configuration registers of the tuner
//
// What this block does
// - bit 7 of synth register picks output divide by 2 (0) or 4 (1)
// - bit 6 set hands charge-pump current to the auto band selection
// - with bit 6 clear, bit 5 picks low or high pump current
// - 5-bit band code in bits 7..3 picks oscillator and seeds auto search; resets 11001
// - auto select bit 2 lets auto circuit choose; clear means written code only
// - with auto select off, bit 1 latches the tuning adc value
// - with auto select off, bit 0 enables tuning adc readout
// - 8-bit lowpass code sets baseband filter corner linearly
// - lowpass code resets to 01001011
// - standby turns off signal path and synthesizer, bus and crystal stay on
// - 4-bit gain code in bits 3..0 steps baseband gain per code
// - shutdown bits 6..4 power down synth loop, divider, oscillator
// - shutdown bits 3..0 power down baseband, mixer, rf amp, front end
// - pointer byte then data bytes, each to the next register until stop
// - every byte is shifted in most significant bit first
`timescale 1ns/100ps
`default_nettype none
module tscr_config_regs
  import tscr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // serial bus
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_sel,
  // synthesizer controls
  output logic            osc_out_divide_sel,
  output logic            pump_current_source_sel,
  output logic            pump_current_level,
  // oscillator controls
  output logic [4:0]      oscillator_band_code,
  output logic            auto_band_select_en,
  output logic            tune_adc_latch,
  output logic            tune_adc_read_en,
  // baseband controls
  output logic [7:0]      baseband_corner_code,
  output logic            standby_ctl,
  output logic            factory_power_down,
  output logic [3:0]      baseband_gain_code,
  // block shutdowns
  output logic            synth_off,
  output logic            divider_off,
  output logic            oscillator_off,
  output logic            baseband_off,
  output logic            rf_mixer_off,
  output logic            rf_amp_off,
  output logic            front_end_off
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SLV,
    ST_SLV_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_DAT,
    ST_DAT_ACK,
    ST_SKIP
  } tscr_state_t;

  tscr_line_if ev ();

  tscr_state_t state_ff;
  tscr_state_t nxt_state;
  logic [7:0]  shift_ff;
  logic [3:0]  bitcnt_ff;
  logic [7:0]  ptr_ff;
  logic [7:0]  synth_ff;
  logic [7:0]  osc_ff;
  logic [7:0]  lowpass_ff;
  logic [7:0]  control_ff;
  logic [7:0]  shutdn_ff;
  logic [7:0]  nxt_synth;
  logic [7:0]  nxt_osc;
  logic [7:0]  nxt_lowpass;
  logic [7:0]  nxt_control;
  logic [7:0]  nxt_shutdn;
  logic        rx_state;
  logic        byte_done;
  logic        addr_match;
  logic        wr_en;

  tscr_line_edge u_edge (
    .clk   (clk),
    .reset (reset),
    .scl   (scl),
    .sda   (sda_in),
    .ev    (ev.src)
  );

  assign rx_state   = (state_ff == ST_SLV) || (state_ff == ST_PTR) || (state_ff == ST_DAT);
  assign byte_done  = rx_state && ev.scl_fall && (bitcnt_ff == TSCR_BITS_PER_BYTE);
  assign addr_match = (shift_ff[7:1] == (TSCR_SLAVE_BASE | {6'h00, addr_sel})) && !shift_ff[0];
  // commit on the falling edge that ends the acknowledge clock
  assign wr_en      = (state_ff == ST_DAT_ACK) && ev.scl_fall;

  // reads are not served here, so a read address is left unacknowledged
  always_comb begin
    nxt_state = state_ff;
    if (ev.stop_det) begin
      nxt_state = ST_IDLE;
    end else if (ev.start_det) begin
      nxt_state = ST_SLV;
    end else if (ev.scl_fall) begin
      case (state_ff)
        ST_SLV: begin
          if (byte_done) begin
            nxt_state = addr_match ? ST_SLV_ACK : ST_SKIP;
          end
        end
        ST_SLV_ACK: nxt_state = ST_PTR;
        ST_PTR: begin
          if (byte_done) begin
            nxt_state = ST_PTR_ACK;
          end
        end
        ST_PTR_ACK: nxt_state = ST_DAT;
        ST_DAT: begin
          if (byte_done) begin
            nxt_state = ST_DAT_ACK;
          end
        end
        ST_DAT_ACK: nxt_state = ST_DAT;
        default:    nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // bit shifter, msb arrives first
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_ff  <= 8'h00;
      bitcnt_ff <= 4'h0;
    end else if (ev.start_det || byte_done) begin
      bitcnt_ff <= 4'h0;
    end else if (rx_state && ev.scl_rise && (bitcnt_ff != TSCR_BITS_PER_BYTE)) begin
      shift_ff  <= {shift_ff[6:0], ev.sda_bit};
      bitcnt_ff <= bitcnt_ff + 4'h1;
    end
  end

  // register pointer with auto increment after each data byte
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_ff <= 8'h00;
    end else if ((state_ff == ST_PTR_ACK) && ev.scl_fall) begin
      ptr_ff <= shift_ff;
    end else if (wr_en) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // pull sda low through the whole acknowledge clock
  assign sda_out = 1'b0;
  assign sda_oe  = (state_ff == ST_SLV_ACK) || (state_ff == ST_PTR_ACK) || (state_ff == ST_DAT_ACK);

  // pointers outside this bank are acknowledged but store nothing
  always_comb begin
    nxt_synth   = synth_ff;
    nxt_osc     = osc_ff;
    nxt_lowpass = lowpass_ff;
    nxt_control = control_ff;
    nxt_shutdn  = shutdn_ff;
    if (reset) begin
      nxt_synth   = TSCR_RST_SYNTH;
      nxt_osc     = TSCR_RST_OSC;
      nxt_lowpass = TSCR_RST_LOWPASS;
      nxt_control = TSCR_RST_CONTROL;
      nxt_shutdn  = TSCR_RST_SHUTDN;
    end else if (wr_en) begin
      case (ptr_ff)
        TSCR_ADDR_SYNTH:   nxt_synth   = shift_ff & TSCR_MASK_SYNTH;
        TSCR_ADDR_OSC:     nxt_osc     = shift_ff & TSCR_MASK_OSC;
        TSCR_ADDR_LOWPASS: nxt_lowpass = shift_ff & TSCR_MASK_LOWPASS;
        TSCR_ADDR_CONTROL: nxt_control = shift_ff & TSCR_MASK_CONTROL;
        TSCR_ADDR_SHUTDN:  nxt_shutdn  = shift_ff & TSCR_MASK_SHUTDN;
        default:           nxt_synth   = synth_ff;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    synth_ff   <= nxt_synth;
    osc_ff     <= nxt_osc;
    lowpass_ff <= nxt_lowpass;
    control_ff <= nxt_control;
    shutdn_ff  <= nxt_shutdn;
  end

  // decode follows next-state values so outputs line up with the stored bytes
  tscr_field_decode u_decode (
    .clk                     (clk),
    .reset                   (reset),
    .synth_val               (nxt_synth),
    .osc_val                 (nxt_osc),
    .lowpass_val             (nxt_lowpass),
    .control_val             (nxt_control),
    .shutdn_val              (nxt_shutdn),
    .osc_out_divide_sel      (osc_out_divide_sel),
    .pump_current_source_sel (pump_current_source_sel),
    .pump_current_level      (pump_current_level),
    .oscillator_band_code    (oscillator_band_code),
    .auto_band_select_en     (auto_band_select_en),
    .tune_adc_latch          (tune_adc_latch),
    .tune_adc_read_en        (tune_adc_read_en),
    .baseband_corner_code    (baseband_corner_code),
    .standby_ctl             (standby_ctl),
    .factory_power_down      (factory_power_down),
    .baseband_gain_code      (baseband_gain_code),
    .synth_off               (synth_off),
    .divider_off             (divider_off),
    .oscillator_off          (oscillator_off),
    .baseband_off            (baseband_off),
    .rf_mixer_off            (rf_mixer_off),
    .rf_amp_off              (rf_amp_off),
    .front_end_off           (front_end_off)
  );

  reset_defaults_a: assert property (@(posedge clk)
    $past(reset) |-> lowpass_ff == TSCR_RST_LOWPASS && osc_ff == TSCR_RST_OSC && synth_ff == TSCR_RST_SYNTH
      && control_ff == TSCR_RST_CONTROL && shutdn_ff == TSCR_RST_SHUTDN)
    else $error("register defaults wrong after reset");

  corner_follows_a: assert property (@(posedge clk) disable iff (reset)
    wr_en && ptr_ff == TSCR_ADDR_LOWPASS |=> baseband_corner_code == $past(shift_ff))
    else $error("corner code not taken from written byte");

  dont_care_a: assert property (@(posedge clk) disable iff (reset)
    synth_ff[4:0] == 5'h00 && control_ff[6] == 1'b0 && control_ff[4] == 1'b0 && shutdn_ff[7] == 1'b0)
    else $error("don't care bit stored");

  ptr_increment_a: assert property (@(posedge clk) disable iff (reset)
    wr_en |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("pointer did not advance after data byte");

  msb_first_a: assert property (@(posedge clk) disable iff (reset)
    rx_state && ev.scl_rise && bitcnt_ff < TSCR_BITS_PER_BYTE && !ev.start_det |=> shift_ff[0] == $past(ev.sda_bit)
      && shift_ff[7:1] == $past(shift_ff[6:0]))
    else $error("bit not shifted in at lsb end");

  commit_after_ack_a: assert property (@(posedge clk) disable iff (reset)
    $changed(control_ff) |-> $past(state_ff) == ST_DAT_ACK && $past(ev.scl_fall))
    else $error("register changed outside acknowledge end");

  ack_hold_a: assert property (@(posedge clk) disable iff (reset)
    byte_done && state_ff == ST_DAT |=> sda_oe throughout (!ev.scl_fall [*1]))
    else $error("acknowledge not driven after data byte");

  gain_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_en && ptr_ff == TSCR_ADDR_CONTROL |=> baseband_gain_code == $past(shift_ff[3:0])
      && standby_ctl == $past(shift_ff[7]))
    else $error("control fields not decoded from written byte");

  divider_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_en && ptr_ff == TSCR_ADDR_SYNTH |=> osc_out_divide_sel == $past(shift_ff[7])
      && pump_current_source_sel == $past(shift_ff[6]))
    else $error("synth fields not decoded from written byte");

  stop_idle_a: assert property (@(posedge clk) disable iff (reset)
    ev.stop_det |=> state_ff == ST_IDLE && !sda_oe)
    else $error("stop did not end the transfer");

  ack_release_a: assert property (@(posedge clk) disable iff (reset)
    sda_oe && ev.scl_fall |=> !sda_oe)
    else $error("acknowledge held past its clock");

  nack_refused_a: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_SLV && byte_done && !addr_match |=> !sda_oe && state_ff == ST_SKIP)
    else $error("foreign or read address acknowledged");

  ptr_load_a: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_PTR_ACK && ev.scl_fall |=> ptr_ff == $past(shift_ff))
    else $error("pointer not loaded from pointer byte");

  hold_between_writes_a: assert property (@(posedge clk) disable iff (reset)
    !wr_en |=> $stable(lowpass_ff) && $stable(osc_ff) && $stable(synth_ff) && $stable(shutdn_ff))
    else $error("register changed without a completed data byte");

  band_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_en && ptr_ff == TSCR_ADDR_OSC |=> oscillator_band_code == $past(shift_ff[7:3])
      && auto_band_select_en == $past(shift_ff[2]))
    else $error("oscillator fields not decoded from written byte");

  shutdown_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_en && ptr_ff == TSCR_ADDR_SHUTDN && !standby_ctl |=> synth_off == $past(shift_ff[6])
      && front_end_off == $past(shift_ff[0]))
    else $error("shutdown fields not decoded from written byte");

endmodule : tscr_config_regs
`default_nettype wire

// File: tb/tscr_bus_master.sv
// serial bus master model that writes the tuner registers
`timescale 1ns/100ps
`default_nettype none
module tscr_bus_master (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // two clk cycles per phase so the slave sees every edge
  task automatic half();
    repeat (2) @(negedge clk);
  endtask : half
  // start or repeated start: sda falls while scl is high
  task automatic bus_start();
    sda_m = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : bus_start
  task automatic bus_stop();
    sda_m = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask : bus_stop
  // n bits, then the ninth clock only when the byte is whole
  task automatic wr_byte(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      sda_m = b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
      half();
    end
    if (n == 8) begin
      sda_m = 1'b1; // released, the pull-up holds it high
      half();
      scl = 1'b1;
      half();
      ack = (sda_w === 1'b0);
      scl = 1'b0;
      half();
    end
  endtask : wr_byte
endmodule : tscr_bus_master
`default_nettype wire

// File: tb/tscr_config_regs_tb.sv
// self-checking bench for the tuner configuration write slave
`timescale 1ns/100ps
`default_nettype none
module tscr_config_regs_tb;
  import tscr_pkg::*;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [7:0] kept;
  } tscr_row_t;
  logic       clk;
  logic       reset;
  logic       addr_sel;
  logic       ack_seen;
  wire        scl;
  wire        sda_m;
  wire        sda_w;
  wire        sda_out;
  wire        sda_oe;
  wire [31:0] obs;
  logic [7:0] mreg [5];
  int         mismatches = 0;
  int         checks_done = 0;
  int         cycles = 0;
  // open drain wire with pull-up
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  tscr_bus_master m (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  tscr_config_regs dut (
    .clk(clk), .reset(reset), .scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .osc_out_divide_sel(obs[31]), .pump_current_source_sel(obs[30]),
    .pump_current_level(obs[29]), .oscillator_band_code(obs[28:24]), .auto_band_select_en(obs[23]),
    .tune_adc_latch(obs[22]), .tune_adc_read_en(obs[21]), .baseband_corner_code(obs[20:13]),
    .standby_ctl(obs[12]), .factory_power_down(obs[11]), .baseband_gain_code(obs[10:7]),
    .synth_off(obs[6]), .divider_off(obs[5]), .oscillator_off(obs[4]), .baseband_off(obs[3]),
    .rf_mixer_off(obs[2]), .rf_amp_off(obs[1]), .front_end_off(obs[0])
  );
  // ptr, data sent, value the register keeps
  tscr_row_t rows [11] = '{
    '{8'h06, 8'h1f, 8'h00},
    '{8'h06, 8'h3f, 8'h20},
    '{8'h06, 8'h60, 8'h60},
    '{8'h07, 8'h53, 8'h53},
    '{8'h07, 8'h07, 8'h07},
    '{8'h08, 8'h0c, 8'h0c},
    '{8'h09, 8'h5f, 8'h0f},
    '{8'h09, 8'h80, 8'h80},
    '{8'h09, 8'h00, 8'h00},
    '{8'h0a, 8'hff, 8'h7f},
    '{8'h0a, 8'h00, 8'h00}
  };
  logic [7:0] burst [5] = '{8'h9a, 8'h30, 8'h03, 8'h01, 8'hff};
  logic [7:0] bad [3] = '{8'hc0, 8'hc3, 8'hc4};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // expected decoded outputs from the model registers
  function automatic logic [31:0] want();
    logic [7:0] s;
    logic [7:0] o;
    logic [7:0] c;
    s = mreg[0];
    o = mreg[1];
    c = mreg[3];
    return {s[7], s[6], ~s[6] & s[5],
            o[7:3], o[2], ~o[2] & o[1], ~o[2] & o[0],
            mreg[2], c[7], c[5], c[3:0],
            mreg[4][6:0] | {7{c[7]}}};
  endfunction : want
  task automatic set_defaults();
    mreg = '{TSCR_RST_SYNTH, TSCR_RST_OSC, TSCR_RST_LOWPASS, TSCR_RST_CONTROL, TSCR_RST_SHUTDN};
  endtask : set_defaults
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic ackw(input logic [7:0] b, input logic exp);
    m.wr_byte(b, 8, ack_seen);
    check(32'(ack_seen), 32'(exp), "acknowledge");
  endtask : ackw
  task automatic wr1(input logic [7:0] s, input logic [7:0] p, input logic [7:0] d);
    m.bus_start();
    ackw(s, 1'b1);
    ackw(p, 1'b1);
    ackw(d, 1'b1);
    m.bus_stop();
  endtask : wr1
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // ceiling well above the roughly 3400 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    reset = 1'b1;
    addr_sel = 1'b0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    set_defaults();
    @(negedge clk);
    check(obs, want(), "reset values");
    check(32'(sda_oe), 32'h0, "bus released");
    foreach (rows[i]) begin
      wr1(8'hc0, rows[i].ptr, rows[i].dat);
      mreg[rows[i].ptr - 8'h06] = rows[i].kept;
      check(obs, want(), "single write");
    end
    // burst from the oscillator register into the unused pointer
    m.bus_start();
    ackw(8'hc0, 1'b1);
    ackw(8'h07, 1'b1);
    foreach (burst[i]) begin
      ackw(burst[i], 1'b1);
    end
    m.bus_stop();
    for (int i = 0; i < 4; i++) begin
      mreg[i + 1] = burst[i];
    end
    check(obs, want(), "burst write");
    wr1(8'hc0, 8'h05, 8'hff);
    check(obs, want(), "unused pointer");
    // strap high: old address, read and foreign address refused
    addr_sel = 1'b1;
    foreach (bad[i]) begin
      m.bus_start();
      ackw(bad[i], 1'b0);
      ackw(8'h08, 1'b0);
      m.bus_stop();
    end
    check(obs, want(), "refused writes");
    wr1(8'hc2, 8'h08, 8'h77);
    mreg[2] = 8'h77;
    check(obs, want(), "strap address");
    addr_sel = 1'b0;
    // byte cut by repeated start must not land
    m.bus_start();
    ackw(8'hc0, 1'b1);
    ackw(8'h08, 1'b1);
    m.wr_byte(8'h11, 5, ack_seen);
    check(obs, want(), "cut byte");
    m.bus_start();
    ackw(8'hc0, 1'b1);
    ackw(8'h09, 1'b1);
    ackw(8'h05, 1'b1);
    m.bus_stop();
    mreg[3] = 8'h05;
    check(obs, want(), "after repeated start");
    // second reset in mid-run
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    set_defaults();
    @(negedge clk);
    check(obs, want(), "second reset");
    stop_test();
  end
endmodule : tscr_config_regs_tb
`default_nettype wire
